// file: core/ewd_timeout_supervisor.sv
// enhanced timeout supervisor: counter, mode logic, timed change window
// assumes a processor core on the same clock driving the register port,
// the restart request and the vector acknowledge; oscillator and fuse are pins
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps

module ewd_timeout_supervisor (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // register port
   input wire logic [ewd_pkg::ADDR_WIDTH-1:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regReadData,
   // core events
   input wire logic restartReq,
   input wire logic vectorAck,
   // pins
   input wire logic oscClockPin,
   input wire logic alwaysOnFusePin,
   // outputs
   output logic timeoutIrq,
   output logic systemResetPulse
);

   // ****************************************
   // declarations
   // ****************************************
   logic oscSync1_reg;
   logic oscSync2_reg;
   logic oscPrev_reg;
   logic fuseSync1_reg;
   logic fuseSync2_reg;
   logic oscTick;
   logic alwaysOnFuse;
   logic [20:0] count_reg;
   logic [3:0] prescalerSelect_reg;
   logic resetEnableBit_reg;
   logic timeoutIrqEnableBit_reg;
   logic timeoutIrqFlag_reg;
   logic supervisorResetFlag_reg;
   logic [7:0] regReadData_reg;
   logic systemResetPulse_reg;
   ewd_pkg::ewd_window_t windowState_reg;
   logic [2:0] windowCount_reg;
   logic resetEnEff;
   logic irqEnEff;
   logic running;
   logic expiry;
   logic ctrlWrite;
   logic causeWrite;
   logic openWrite;
   logic changeWrite;
   logic [3:0] writtenPsel;
   logic expiryIrq;
   logic expiryReset;
   logic [7:0] ctrlReadValue;
   logic windowOpen;
   logic windowLastCycle;
   logic pselAccept;
   logic ctrlRead;
   logic causeRead;

   // ****************************************
   // local constants
   // ****************************************
   localparam logic [2:0] WINDOW_LAST = 3'h1;
   localparam logic [2:0] WINDOW_IDLE = 3'h0;
   localparam logic [2:0] WINDOW_STEP = 3'h1;
   localparam logic [20:0] COUNT_ZERO = 21'h0;
   localparam logic [20:0] COUNT_STEP = 21'h1;
   localparam int PSEL_TOP_BIT = 3;

   // ****************************************
   // helper functions
   // ****************************************
   function automatic logic [20:0] timeoutLimit(input logic [3:0] psel);
      timeoutLimit = ewd_pkg::BASE_TIMEOUT_CYCLES << psel;
   endfunction : timeoutLimit

   function automatic logic isControlAddr(input logic [ewd_pkg::ADDR_WIDTH-1:0] addr);
      isControlAddr = (addr == ewd_pkg::SUPERVISOR_CONTROL_STATUS_OFFSET);
   endfunction : isControlAddr

   function automatic logic isCauseAddr(input logic [ewd_pkg::ADDR_WIDTH-1:0] addr);
      isCauseAddr = (addr == ewd_pkg::RESET_CAUSE_STATUS_OFFSET);
   endfunction : isCauseAddr

   // reserved codes above the top code are refused
   function automatic logic pselSupported(input logic [3:0] psel);
      pselSupported = (psel <= ewd_pkg::PRESCALER_MAX_CODE);
   endfunction : pselSupported

   // ****************************************
   // pin synchronisers
   // ****************************************
   always_ff @(posedge clock) begin
      if (reset) begin
         oscSync1_reg <= 1'b0;
         oscSync2_reg <= 1'b0;
         oscPrev_reg <= 1'b0;
      end else begin
         oscSync1_reg <= oscClockPin;
         oscSync2_reg <= oscSync1_reg;
         oscPrev_reg <= oscSync2_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         fuseSync1_reg <= 1'b0;
         fuseSync2_reg <= 1'b0;
      end else begin
         fuseSync1_reg <= alwaysOnFusePin;
         fuseSync2_reg <= fuseSync1_reg;
      end
   end

   // one tick per oscillator rising edge
   assign oscTick = oscSync2_reg & ~oscPrev_reg;
   assign alwaysOnFuse = fuseSync2_reg;

   // ****************************************
   // effective mode
   // ****************************************
   // fuse overrides both stored enables; reset flag overrides only the stored reset enable
   assign resetEnEff = resetEnableBit_reg | supervisorResetFlag_reg | alwaysOnFuse;
   assign irqEnEff = timeoutIrqEnableBit_reg & ~alwaysOnFuse;
   assign running = resetEnEff | irqEnEff;

   // ****************************************
   // register decode
   // ****************************************
   always_comb begin
      ctrlWrite = 1'b0;
      causeWrite = 1'b0;
      if (regWrite && isControlAddr(regAddr)) begin
         ctrlWrite = 1'b1;
      end else if (regWrite && isCauseAddr(regAddr)) begin
         causeWrite = 1'b1;
      end
   end

   always_comb begin
      ctrlRead = 1'b0;
      causeRead = 1'b0;
      if (regRead && isControlAddr(regAddr)) begin
         ctrlRead = 1'b1;
      end else if (regRead && isCauseAddr(regAddr)) begin
         causeRead = 1'b1;
      end
   end

   // opening write sets change enable and reset enable together
   assign openWrite = ctrlWrite & regWriteData[ewd_pkg::CHANGE_ENABLE_BIT]
      & regWriteData[ewd_pkg::RESET_ENABLE_BIT];
   // second write, change enable clear, inside the window
   assign changeWrite = ctrlWrite & ~regWriteData[ewd_pkg::CHANGE_ENABLE_BIT]
      & windowOpen;
   assign writtenPsel = {regWriteData[ewd_pkg::PSEL_HIGH_BIT],
      regWriteData[ewd_pkg::PSEL_LOW_MSB:0]};

   // ****************************************
   // window status
   // ****************************************
   assign windowOpen = (windowState_reg == ewd_pkg::WIN_OPEN);
   assign windowLastCycle = (windowCount_reg == WINDOW_LAST);
   assign pselAccept = changeWrite && pselSupported(writtenPsel);

   // ****************************************
   // change window
   // ****************************************
   always_ff @(posedge clock) begin
      if (reset) begin
         windowState_reg <= ewd_pkg::WIN_CLOSED;
         windowCount_reg <= WINDOW_IDLE;
      end else begin
         case (windowState_reg)
            ewd_pkg::WIN_CLOSED: begin
               if (openWrite) begin
                  windowState_reg <= ewd_pkg::WIN_OPEN;
                  windowCount_reg <= ewd_pkg::CHANGE_WINDOW_CYCLES;
               end
            end
            ewd_pkg::WIN_OPEN: begin
               if (openWrite) begin
                  windowCount_reg <= ewd_pkg::CHANGE_WINDOW_CYCLES;
               end else if (changeWrite || windowLastCycle) begin
                  windowState_reg <= ewd_pkg::WIN_CLOSED;
                  windowCount_reg <= WINDOW_IDLE;
               end else begin
                  windowCount_reg <= windowCount_reg - WINDOW_STEP;
               end
            end
            default: begin
               windowState_reg <= ewd_pkg::WIN_CLOSED;
               windowCount_reg <= WINDOW_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // protected settings
   // ****************************************
   always_ff @(posedge clock) begin
      if (reset) begin
         resetEnableBit_reg <= 1'b0;
      end else if (ctrlWrite && regWriteData[ewd_pkg::RESET_ENABLE_BIT]) begin
         resetEnableBit_reg <= 1'b1;
      end else if (changeWrite && !supervisorResetFlag_reg) begin
         resetEnableBit_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         prescalerSelect_reg <= ewd_pkg::PSEL_RESET;
      end else if (pselAccept) begin
         prescalerSelect_reg <= writtenPsel;
      end
   end

   // ****************************************
   // interrupt enable
   // ****************************************
   always_ff @(posedge clock) begin
      if (reset) begin
         timeoutIrqEnableBit_reg <= 1'b0;
      end else if (ctrlWrite) begin
         timeoutIrqEnableBit_reg <= regWriteData[ewd_pkg::IRQ_ENABLE_BIT];
      end else if (vectorAck && resetEnEff) begin
         timeoutIrqEnableBit_reg <= 1'b0;
      end
   end

   // ****************************************
   // counter
   // ****************************************
   assign expiry = running && oscTick
      && (count_reg == timeoutLimit(prescalerSelect_reg) - COUNT_STEP);

   always_ff @(posedge clock) begin
      if (reset) begin
         count_reg <= COUNT_ZERO;
      end else if (restartReq || !running || expiry) begin
         count_reg <= COUNT_ZERO;
      end else if (oscTick) begin
         count_reg <= count_reg + COUNT_STEP;
      end
   end

   // ****************************************
   // expiry actions
   // ****************************************
   // combined mode: first expiry interrupts, a pending one then resets
   assign expiryIrq = expiry && irqEnEff && !(resetEnEff && timeoutIrqFlag_reg);
   assign expiryReset = expiry && resetEnEff && !expiryIrq;

   always_ff @(posedge clock) begin
      if (reset) begin
         timeoutIrqFlag_reg <= 1'b0;
      end else if (expiryIrq) begin
         timeoutIrqFlag_reg <= 1'b1;
      end else if (vectorAck || (ctrlWrite && regWriteData[ewd_pkg::IRQ_FLAG_BIT])) begin
         timeoutIrqFlag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         systemResetPulse_reg <= 1'b0;
      end else begin
         systemResetPulse_reg <= expiryReset;
      end
   end

   // flag survives the system reset this block issues
   always_ff @(posedge clock) begin
      if (reset) begin
         supervisorResetFlag_reg <= 1'b0;
      end else if (expiryReset) begin
         supervisorResetFlag_reg <= 1'b1;
      end else if (causeWrite && !regWriteData[ewd_pkg::RESET_FLAG_BIT]) begin
         supervisorResetFlag_reg <= 1'b0;
      end
   end

   // ****************************************
   // read path
   // ****************************************
   always_comb begin
      ctrlReadValue = ewd_pkg::READ_ZERO;
      ctrlReadValue[ewd_pkg::IRQ_FLAG_BIT] = timeoutIrqFlag_reg;
      ctrlReadValue[ewd_pkg::IRQ_ENABLE_BIT] = irqEnEff;
      ctrlReadValue[ewd_pkg::PSEL_HIGH_BIT] = prescalerSelect_reg[PSEL_TOP_BIT];
      ctrlReadValue[ewd_pkg::CHANGE_ENABLE_BIT] = windowOpen;
      ctrlReadValue[ewd_pkg::RESET_ENABLE_BIT] = resetEnEff;
      ctrlReadValue[ewd_pkg::PSEL_LOW_MSB:0] = prescalerSelect_reg[2:0];
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         regReadData_reg <= ewd_pkg::READ_ZERO;
      end else if (ctrlRead) begin
         regReadData_reg <= ctrlReadValue;
      end else if (causeRead) begin
         regReadData_reg <= ewd_pkg::READ_ZERO;
         regReadData_reg[ewd_pkg::RESET_FLAG_BIT] <= supervisorResetFlag_reg;
      end else begin
         regReadData_reg <= ewd_pkg::READ_ZERO;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign regReadData = regReadData_reg;
   // level request, usable as a wake source from sleep
   assign timeoutIrq = timeoutIrqFlag_reg & irqEnEff;
   assign systemResetPulse = systemResetPulse_reg;

endmodule : ewd_timeout_supervisor

// file: shared/ewd_pkg.sv
// constants of the enhanced timeout supervisor
// assumes one system clock; the low-frequency oscillator arrives as a pin
package ewd_pkg;

   // ****************************************
   // clocking and timing
   // ****************************************
   localparam int SYS_CLOCK_MHZ = 250;
   localparam int OSC_FREQ_KHZ = 128;
   // timed change window in system clock cycles
   localparam logic [2:0] CHANGE_WINDOW_CYCLES = 3'h4;
   // shortest time-out in oscillator cycles, doubled per prescaler code step
   localparam logic [20:0] BASE_TIMEOUT_CYCLES = 21'h000800;
   localparam logic [3:0] PRESCALER_MAX_CODE = 4'h9;
   localparam int TIMEOUT_SHORTEST_MS = 16;
   localparam int TIMEOUT_LONGEST_MS = 8000;

   // ****************************************
   // register map
   // ****************************************
   localparam int ADDR_WIDTH = 4;
   localparam logic [3:0] SUPERVISOR_CONTROL_STATUS_OFFSET = 4'h0;
   localparam logic [3:0] RESET_CAUSE_STATUS_OFFSET = 4'h1;

   // control/status field positions
   localparam int IRQ_FLAG_BIT = 7;
   localparam int IRQ_ENABLE_BIT = 6;
   localparam int PSEL_HIGH_BIT = 5;
   localparam int CHANGE_ENABLE_BIT = 4;
   localparam int RESET_ENABLE_BIT = 3;
   localparam int PSEL_LOW_MSB = 2;
   // reset cause field position
   localparam int RESET_FLAG_BIT = 3;

   // reset values
   localparam logic [3:0] PSEL_RESET = 4'h0;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // ****************************************
   // change window states
   // ****************************************
   typedef enum logic [0:0] {
      WIN_CLOSED = 1'b0,
      WIN_OPEN = 1'b1
   } ewd_window_t;

endpackage : ewd_pkg

// file: testbench/ewd_chk.sv
// port checker of the timeout supervisor
// assumes binding onto ewd_timeout_supervisor, one clock domain
`timescale 1ns/10ps
module ewd_chk (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // register port
   input wire logic [ewd_pkg::ADDR_WIDTH-1:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regReadData,
   // events and pins
   input wire logic restartReq,
   input wire logic vectorAck,
   input wire logic oscClockPin,
   input wire logic alwaysOnFusePin,
   // outputs
   input wire logic timeoutIrq,
   input wire logic systemResetPulse
);
   // ****************************************
   // helper counters and assertions
   // ****************************************
   logic [15:0] quiet;
   logic dirty;
   logic [3:0] upCnt;
   wire ctlW = regWrite && regAddr == ewd_pkg::SUPERVISOR_CONTROL_STATUS_OFFSET;
   wire ctlR = regRead && regAddr == ewd_pkg::SUPERVISOR_CONTROL_STATUS_OFFSET;
   always_ff @(posedge clock) begin
      if (reset || restartReq) quiet <= 16'h0000;
      else if (quiet != 16'hffff) quiet <= quiet + 16'h0001;
   end
   always_ff @(posedge clock) begin
      if (reset || restartReq) dirty <= 1'b0;
      else if (ctlW) dirty <= 1'b1;
   end
   always_ff @(posedge clock) begin
      if (reset) upCnt <= 4'h0;
      else if (upCnt != 4'hf) upCnt <= upCnt + 4'h1;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   sequence openSeq;
      ctlW && regWriteData[4] && regWriteData[3];
   endsequence
   a_pulse_one_cycle: assert property (systemResetPulse |=> !systemResetPulse)
      else $error("reset pulse longer than one cycle");
   a_restart_holds_off: assert property ((systemResetPulse || $rose(timeoutIrq)) && !dirty
      |-> quiet > 16'h0fa0)
      else $error("expiry too soon after restart");
   a_fuse_locks_bits: assert property (ctlR && alwaysOnFusePin && $past(alwaysOnFusePin, 5)
      && upCnt > 4'h5 |=> regReadData[3] && !regReadData[6])
      else $error("fuse does not lock enables");
   a_vector_clears_irq: assert property (vectorAck |=> !timeoutIrq)
      else $error("vector does not clear irq");
   a_written_one_clears: assert property (ctlW && regWriteData[7] |=> !timeoutIrq)
      else $error("written one does not clear irq");
   a_irq_level_holds: assert property (timeoutIrq && !vectorAck && !ctlW |=> timeoutIrq)
      else $error("irq dropped without a clear");
   a_window_opens: assert property (openSeq ##1 !regWrite ##1 ctlR |=> regReadData[4])
      else $error("change window not open");
   a_window_closes: assert property (openSeq ##1 (!regWrite)[*4] ##1 ctlR
      |=> !regReadData[4])
      else $error("change window not closed");
endmodule : ewd_chk

bind ewd_timeout_supervisor ewd_chk u_chk (.clock(clock), .reset(reset), .regAddr(regAddr),
   .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
   .regReadData(regReadData), .restartReq(restartReq), .vectorAck(vectorAck),
   .oscClockPin(oscClockPin), .alwaysOnFusePin(alwaysOnFusePin),
   .timeoutIrq(timeoutIrq), .systemResetPulse(systemResetPulse));

// file: testbench/tb_top.sv
// self-checking bench of the timeout supervisor
// assumes a free stand-in oscillator of four clocks per cycle
`timescale 1ns/10ps
module tb_top;
   // ****************************************
   // stimulus, tasks and main sequence
   // ****************************************
   localparam logic [3:0] CTL = ewd_pkg::SUPERVISOR_CONTROL_STATUS_OFFSET;
   localparam logic [3:0] CAU = ewd_pkg::RESET_CAUSE_STATUS_OFFSET;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWriteData = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regReadData;
   logic restartReq = 1'b0;
   logic vectorAck = 1'b0;
   logic oscClockPin = 1'b0;
   logic alwaysOnFusePin = 1'b0;
   logic timeoutIrq;
   logic systemResetPulse;
   logic [7:0] d;
   logic [3:0] a;
   int error_cnt = 0;
   int compares = 0;
   int pulses = 0;
   int n;
   always #2 clock = ~clock;
   always #8 oscClockPin = ~oscClockPin;
   always @(negedge clock) if (systemResetPulse === 1'b1) pulses++;
   ewd_timeout_supervisor dut (.clock(clock), .reset(reset), .regAddr(regAddr),
      .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
      .regReadData(regReadData), .restartReq(restartReq), .vectorAck(vectorAck),
      .oscClockPin(oscClockPin), .alwaysOnFusePin(alwaysOnFusePin),
      .timeoutIrq(timeoutIrq), .systemResetPulse(systemResetPulse));
   task automatic end_sim();
      $display("mismatches %0d comparisons %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] ad, input logic [7:0] v);
      @(posedge clock);
      regAddr <= ad;
      regWriteData <= v;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask : wr
   task automatic rc(input logic [3:0] ad, input logic [7:0] exp);
      @(posedge clock);
      regAddr <= ad;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      @(negedge clock);
      chk(regReadData, exp);
   endtask : rc
   task automatic restart();
      @(posedge clock);
      restartReq <= 1'b1;
      @(posedge clock);
      restartReq <= 1'b0;
   endtask : restart
   task automatic waitOut(input bit rst, output int cyc);
      cyc = 0;
      while ((rst ? systemResetPulse : timeoutIrq) !== 1'b1) begin
         @(negedge clock);
         cyc++;
         if (cyc > 40000) begin
            error_cnt++;
            end_sim();
         end
      end
   endtask : waitOut
   initial begin
      n = $urandom(35275);
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      rc(CTL, 8'h00);
      rc(CAU, 8'h00);
      a = 4'h2 + 4'($urandom % 14);
      wr(a, 8'($urandom));
      rc(a, 8'h00);
      rc(CTL, 8'h00);
      // irq-only mode, restarted in time, then left to expire
      wr(CTL, 8'h40);
      repeat (3) begin
         repeat (4000 + $urandom % 3000) @(posedge clock);
         restart();
      end
      waitOut(1'b0, n);
      chk((n + 16) / 32, 8192 / 32);
      chk(pulses, 0);
      rc(CTL, 8'hc0);
      wr(CTL, 8'hc0);
      rc(CTL, 8'h40);
      wr(CTL, 8'h00);
      // combined mode: irq first, reset on the next expiry
      wr(CTL, 8'h48);
      restart();
      waitOut(1'b0, n);
      chk(pulses, 0);
      waitOut(1'b1, n);
      chk((n + 16) / 32, 8192 / 32);
      chk(timeoutIrq, 1'b1);
      rc(CAU, 8'h08);
      rc(CTL, 8'hc8);
      @(posedge clock);
      vectorAck <= 1'b1;
      @(posedge clock);
      vectorAck <= 1'b0;
      rc(CTL, 8'h08);
      wr(CTL, 8'h18);
      wr(CTL, 8'h00);
      rc(CTL, 8'h08);
      wr(CAU, 8'h00);
      rc(CAU, 8'h00);
      wr(CTL, 8'h00);
      rc(CTL, 8'h08);
      wr(CTL, 8'h18);
      repeat (3) @(posedge clock);
      rc(CTL, 8'h08);
      wr(CTL, 8'h00);
      rc(CTL, 8'h08);
      wr(CTL, 8'h18);
      rc(CTL, 8'h18);
      wr(CTL, 8'h2a);
      rc(CTL, 8'h08);
      wr(CTL, 8'h18);
      repeat ($urandom % 3) @(posedge clock);
      wr(CTL, 8'h09);
      rc(CTL, 8'h09);
      restart();
      waitOut(1'b1, n);
      chk((n + 16) / 32, 16384 / 32);
      chk(timeoutIrq, 1'b0);
      rc(CAU, 8'h08);
      wr(CAU, 8'h00);
      wr(CTL, 8'h19);
      wr(CTL, 8'h00);
      rc(CTL, 8'h00);
      // fuse forces reset-only mode
      @(posedge clock);
      alwaysOnFusePin <= 1'b1;
      repeat (6) @(posedge clock);
      wr(CTL, 8'h40);
      rc(CTL, 8'h08);
      end_sim();
   end
endmodule : tb_top
